// ### rdct_cfg.svh
// constants for the reload timer bank
`ifndef RDCT_CFG_SVH
`define RDCT_CFG_SVH
`define RDCT_NUM_TIMERS 6
`define RDCT_CNT_W 16
`define RDCT_NUM_EVT 4
`define RDCT_PRE_W 8
`define RDCT_DIV_4 2'h0
`define RDCT_DIV_16 2'h1
`define RDCT_DIV_64 2'h2
`define RDCT_DIV_256 2'h3
`define RDCT_TAP_4 8'h03
`define RDCT_TAP_16 8'h0F
`define RDCT_TAP_64 8'h3F
`define RDCT_TAP_256 8'hFF
`define RDCT_CNT_RST 16'h0000
`endif

// ### rdct_channel.sv
// one 16-bit reloadable down counter channel
`timescale 1ns/1ns
`default_nettype none
`include "rdct_cfg.svh"
module rdct_channel (
  input wire logic clk,
  input wire logic rstSync_b,
  rdct_tick_if.dst tk,
  input wire logic start,
  input wire logic stop,
  input wire logic [`RDCT_CNT_W-1:0] reloadVal,
  input wire rdct_pkg::rdct_mode_t mode,
  output logic [`RDCT_CNT_W-1:0] count,
  output logic running,
  output logic endPulse,
  output logic toggleOut
);
  typedef struct packed {
    rdct_pkg::rdct_state_t st;
    logic [`RDCT_CNT_W-1:0] cnt;
    logic endp;
    logic tog;
  } rdct_ch_t;
  rdct_ch_t state_ff;
  rdct_ch_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.endp = 1'b0;
    if (tk.clkOn) begin // see RULE6
      if (stop) begin
        nxt_state.st = rdct_pkg::RDCT_IDLE;
      end else if (start) begin
        nxt_state.st = rdct_pkg::RDCT_RUN;
        nxt_state.cnt = reloadVal;
      end else if (state_ff.st == rdct_pkg::RDCT_RUN && tk.tick) begin
        if (state_ff.cnt == `RDCT_CNT_RST || state_ff.cnt == 16'h0001) begin
          nxt_state.endp = 1'b1; // see RULE7
          nxt_state.tog = ~state_ff.tog; // see RULE5
          if (mode == rdct_pkg::RDCT_CONT) begin // see RULE3
            nxt_state.cnt = reloadVal;
          end else begin
            nxt_state.cnt = `RDCT_CNT_RST;
            nxt_state.st = rdct_pkg::RDCT_DONE;
          end
        end else begin
          nxt_state.cnt = state_ff.cnt - 16'h0001; // see RULE1
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state_ff <= '{rdct_pkg::RDCT_IDLE, `RDCT_CNT_RST, 1'b0, 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign count = state_ff.cnt;
  assign running = (state_ff.st == rdct_pkg::RDCT_RUN);
  assign endPulse = state_ff.endp;
  assign toggleOut = state_ff.tog;
endmodule : rdct_channel
`default_nettype wire

// ### rdct_chk_sva.sv
// concurrent checks on the reload timer bank ports
`timescale 1ns/1ns
`default_nettype none
module rdct_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] clkEnable,
  input wire logic [5:0] start,
  input wire logic [5:0] stop,
  input wire logic [5:0] contMode,
  input wire logic [5:0] running,
  input wire logic [5:0] endFlag,
  input wire logic [11:0] divSel,
  input wire logic [95:0] reloadVal,
  input wire logic [95:0] count,
  input wire logic [3:0] evtSel,
  input wire logic [3:0] evtPin,
  input wire logic [1:0] outPin,
  input wire logic [1:0] outPinOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  sequence sLoad0;
    start[0] && clkEnable[0] && !stop[0] && reloadVal[15:0] > 16'h0002 && divSel[1:0] == 2'h0
      && !evtSel[0];
  endsequence
  a_start_load: assert property (start[0] && clkEnable[0] && !stop[0] |=> running[0]
    && count[15:0] == $past(reloadVal[15:0])) else $error("start did not load");
  a_div4_tick: assert property (sLoad0 ##1 clkEnable[0] [*3] |-> $stable(count[15:0])
    ##[1:3] count[15:0] == $past(count[15:0]) - 16'h0001) else $error("bad first tick");
  a_dec_one: assert property ($past(running[0]) && !$past(start[0]) && $past(count[15:0]) >
    16'h0001 && $changed(count[15:0]) |-> count[15:0] == $past(count[15:0]) - 16'h0001)
    else $error("step not one");
  a_gate_hold: assert property (!clkEnable[0] |=> $stable(count[15:0]) && $stable(running[0]))
    else $error("gated channel moved");
  a_single_end: assert property ($fell(running[2]) && !$past(stop[2]) |->
    count[47:32] == 16'h0000 ##[0:1] endFlag[2]) else $error("single end wrong");
  // the pin flips at the end edge, the sticky flag one edge later
  a_pin_toggle: assert property ($rose(endFlag[4]) |-> outPin[0] != $past(outPin[0], 2))
    else $error("pin did not toggle");
  a_cont_keep: assert property (contMode[4] && running[4] && !stop[4] |=> running[4])
    else $error("continuous channel stopped");
  a_oe_on: assert property (outPinOe == 2'h3) else $error("pin not driven");
  a_evt_quiet: assert property (evtSel[1] && clkEnable[1] && !start[1] && !evtPin[1]
    |=> $stable(count[31:16])) else $error("no event moved");
  a_evt_step: assert property (evtSel[1] && clkEnable[1] && running[1] &&
    !start[1] && !stop[1] && evtPin[1] && !$past(evtPin[1]) && count[31:16] > 16'h0001
    |=> count[31:16] == $past(count[31:16]) - 16'h0001) else $error("event did not step");
endmodule : rdct_chk
bind rdct_top rdct_chk u_chk (.clk(clk), .rst_b(rst_b), .clkEnable(clkEnable), .start(start),
  .stop(stop), .contMode(contMode), .running(running), .endFlag(endFlag), .divSel(divSel),
  .reloadVal(reloadVal), .count(count), .evtSel(evtSel), .evtPin(evtPin), .outPin(outPin),
  .outPinOe(outPinOe));
`default_nettype wire

// ### rdct_pkg.sv
// types for the reload timer bank
package rdct_pkg;
  typedef enum logic {RDCT_SINGLE, RDCT_CONT} rdct_mode_t;
  typedef enum logic [1:0] {RDCT_IDLE, RDCT_RUN, RDCT_DONE} rdct_state_t;
endpackage : rdct_pkg

// ### rdct_tick_if.sv
// tick and clock-gate signals shared between bank and one channel
`timescale 1ns/1ns
`default_nettype none
interface rdct_tick_if;
  logic tick;
  logic clkOn;
  modport src (output tick, output clkOn);
  modport dst (input tick, input clkOn);
endinterface : rdct_tick_if
`default_nettype wire

// ### rdct_top.sv
// bank of six reloadable down-counting timers with prescalers
// Overview of operation
// RULE1 - six channels, 16-bit count, decrement per tick
// RULE2 - prescaler divides system clock by 4/16/64/256
// RULE3 - single-pass or continuous mode per channel
// RULE4 - channels 0..3 may count input pin events
// RULE5 - channels 4,5 drive an output pin
// RULE6 - gated-off channel freezes count, state, toggle and prescaler; endClr still clears its end flag
// RULE7 - zero raises end flag; reload or stop
`timescale 1ns/1ns
`default_nettype none
`include "rdct_cfg.svh"
module rdct_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`RDCT_NUM_TIMERS-1:0] clkEnable,
  input wire logic [`RDCT_NUM_TIMERS-1:0] start,
  input wire logic [`RDCT_NUM_TIMERS-1:0] stop,
  input wire logic [`RDCT_NUM_TIMERS-1:0] contMode,
  input wire logic [`RDCT_NUM_TIMERS*2-1:0] divSel,
  input wire logic [`RDCT_NUM_TIMERS*`RDCT_CNT_W-1:0] reloadVal,
  input wire logic [`RDCT_NUM_EVT-1:0] evtSel,
  input wire logic [`RDCT_NUM_EVT-1:0] evtPin,
  input wire logic [`RDCT_NUM_TIMERS-1:0] endClr,
  output logic [`RDCT_NUM_TIMERS*`RDCT_CNT_W-1:0] count,
  output logic [`RDCT_NUM_TIMERS-1:0] running,
  output logic [`RDCT_NUM_TIMERS-1:0] endFlag,
  output logic [1:0] outPin,
  output logic [1:0] outPinOe
);
  ////////////////////////////////////////////////////////////////////////
  logic rstMeta_ff;
  logic rstSync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_ff <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_b <= rstMeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [`RDCT_NUM_TIMERS-1:0][`RDCT_PRE_W-1:0] pre;
    logic [`RDCT_NUM_EVT-1:0] evtLast;
    logic [`RDCT_NUM_TIMERS-1:0] endf;
  } rdct_top_t;
  rdct_top_t state_ff;
  rdct_top_t nxt_state;
  logic [`RDCT_NUM_TIMERS-1:0] tickVec;
  logic [`RDCT_NUM_TIMERS-1:0] endPulse;
  logic [`RDCT_NUM_TIMERS-1:0] togVec;

  function automatic logic [`RDCT_PRE_W-1:0] tapOf(input logic [1:0] sel);
    logic [`RDCT_PRE_W-1:0] t;
    unique case (sel)
      `RDCT_DIV_4: t = `RDCT_TAP_4;
      `RDCT_DIV_16: t = `RDCT_TAP_16;
      `RDCT_DIV_64: t = `RDCT_TAP_64;
      `RDCT_DIV_256: t = `RDCT_TAP_256;
    endcase
    return t;
  endfunction : tapOf

  always_comb begin
    nxt_state = state_ff;
    tickVec = '0;
    for (int i = 0; i < `RDCT_NUM_TIMERS; i++) begin
      if (clkEnable[i]) begin // see RULE6
        // prescaler restarts with each start so the first period is whole
        if (start[i] || state_ff.pre[i] == tapOf(divSel[2*i +: 2])) begin // see RULE2
          nxt_state.pre[i] = '0;
        end else begin
          nxt_state.pre[i] = state_ff.pre[i] + 8'h01;
        end
        tickVec[i] = !start[i] && state_ff.pre[i] == tapOf(divSel[2*i +: 2]);
      end
      // set wins over clear
      nxt_state.endf[i] = endPulse[i] | (state_ff.endf[i] & ~endClr[i]); // see RULE7
    end
    for (int j = 0; j < `RDCT_NUM_EVT; j++) begin
      nxt_state.evtLast[j] = evtPin[j];
      if (evtSel[j]) begin // see RULE4
        // rising edge only; pin is already synchronous to clk
        tickVec[j] = clkEnable[j] && evtPin[j] && !state_ff.evtLast[j];
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < `RDCT_NUM_TIMERS; g++) begin : gCh
    rdct_tick_if tk ();
    assign tk.tick = tickVec[g];
    assign tk.clkOn = clkEnable[g];
    rdct_channel u_rdct_channel (
      .clk(clk),
      .rstSync_b(rstSync_b),
      .tk(tk),
      .start(start[g]),
      .stop(stop[g]),
      .reloadVal(reloadVal[g*`RDCT_CNT_W +: `RDCT_CNT_W]),
      .mode(rdct_pkg::rdct_mode_t'(contMode[g])),
      .count(count[g*`RDCT_CNT_W +: `RDCT_CNT_W]),
      .running(running[g]),
      .endPulse(endPulse[g]),
      .toggleOut(togVec[g])
    ); // see RULE1
  end

  assign endFlag = state_ff.endf;
  assign outPin = togVec[`RDCT_NUM_TIMERS-1 -: 2]; // see RULE5
  assign outPinOe = 2'h3;
endmodule : rdct_top
`default_nettype wire

// ### reloadable_down_counter_timers_tb.sv
// directed bench for the reload timer bank
`timescale 1ns/1ns
`default_nettype none
module reloadable_down_counter_timers_tb;
  logic clk, rst_b;
  logic [5:0] clkEnable, start, stop, contMode, endClr, running, endFlag;
  logic [11:0] divSel;
  logic [95:0] reloadVal, count;
  logic [3:0] evtSel, evtPin;
  logic [1:0] outPin, outPinOe;
  logic [15:0] s;
  int errors, total_checks, n;
  wire logic [7:0] mon = {outPin, endFlag};
  rdct_top u_rdct_top (.clk(clk), .rst_b(rst_b), .clkEnable(clkEnable), .start(start),
    .stop(stop), .contMode(contMode), .divSel(divSel), .reloadVal(reloadVal), .evtSel(evtSel),
    .evtPin(evtPin), .endClr(endClr), .count(count), .running(running), .endFlag(endFlag),
    .outPin(outPin), .outPinOe(outPinOe));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task tk(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tk
  task chk(string w, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task go(int i);
    @(posedge clk) start[i] <= 1'b1;
    @(posedge clk) start[i] <= 1'b0;
    #1;
  endtask : go
  task waitChg(int i);
    logic v;
    v = mon[i];
    n = 0;
    while (mon[i] === v) begin
      tk(1);
      n++;
      if (n > 3000) begin
        errors++;
        stop_test();
      end
    end
  endtask : waitChg
  task stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin
    {clkEnable, start, stop, endClr, divSel, reloadVal, evtPin} = '0;
    contMode = 6'h10;
    evtSel = 4'h2;
    rst_b = 1'b0;
    tk(2);
    @(posedge clk) rst_b <= 1'b1;
    clkEnable <= 6'h3F;
    tk(4);
    chk("idle", 16'h0000, {2'h0, running, endFlag, outPin});
    chk("oe", 16'h0003, {14'h0, outPinOe});
    $display("reset done");
    @(posedge clk) reloadVal[47:32] <= 16'h0003;
    go(2);
    waitChg(2);
    tk(1);
    chk("single count", 16'h0000, count[47:32]);
    chk("single run", 16'h0000, {15'h0, running[2]});
    @(posedge clk) endClr[2] <= 1'b1;
    @(posedge clk) endClr[2] <= 1'b0;
    tk(1);
    chk("flag clear", 16'h0000, {15'h0, endFlag[2]});
    $display("single done");
    // the toggle pin gives an exact period without touching count
    for (int d = 0; d < 4; d++) begin
      @(posedge clk) divSel[9:8] <= d[1:0];
      reloadVal[79:64] <= 16'h0002;
      go(4);
      waitChg(6);
      waitChg(6);
      chk("period", 16'h0008 << (2 * d), n[15:0]);
    end
    $display("divider done");
    @(posedge clk) reloadVal[15:0] <= 16'h0064;
    contMode[0] <= 1'b1;
    go(0);
    tk(10);
    @(posedge clk) clkEnable[0] <= 1'b0;
    tk(2);
    s = count[15:0];
    tk(20);
    chk("frozen", s, count[15:0]);
    @(posedge clk) clkEnable[0] <= 1'b1;
    tk(20);
    // twenty enabled edges hold exactly five divide-by-4 ticks
    chk("resumed", s - 16'h0005, count[15:0]);
    @(posedge clk) stop[0] <= 1'b1;
    @(posedge clk) stop[0] <= 1'b0;
    tk(1);
    s = count[15:0];
    chk("stopped", 16'h0000, {15'h0, running[0]});
    tk(8);
    chk("stop hold", s, count[15:0]);
    $display("gate done");
    @(posedge clk) reloadVal[31:16] <= 16'h0005;
    go(1);
    repeat (3) begin
      @(posedge clk) evtPin[1] <= 1'b1;
      @(posedge clk) evtPin[1] <= 1'b0;
      tk(3);
    end
    chk("events", 16'h0002, count[31:16]);
    $display("event done");
    @(posedge clk) rst_b <= 1'b0;
    tk(2);
    chk("mid reset", 16'h0000, {2'h0, running, endFlag, outPin});
    chk("reset count", 16'h0000, count[79:64]);
    @(posedge clk) rst_b <= 1'b1;
    tk(4);
    go(2);
    chk("restart", 16'h0001, {15'h0, running[2]});
    $display("mid reset done");
    stop_test();
  end
endmodule : reloadable_down_counter_timers_tb
`default_nettype wire
